//--- rtl/roc_ctrl_cmds.sv
// roc_ctrl_cmds: control-type radio operation command executor with apb registers
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module roc_ctrl_cmds
    import roc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rtc_tick,
    input  wire logic [31:0] timer_value,
    output logic             timer_start,
    output logic             rtc_capture_arm,
    output logic             timer_adjust,
    output logic [31:0]      timer_adjust_value,
    output logic             rtc_update_enable,
    input  wire logic        command_register_busy,
    output logic             imm_req,
    output logic [31:0]      imm_word,
    input  wire logic        imm_done,
    input  wire logic [31:0] imm_status_word,
    output logic             op_done,
    output logic [1:0]       op_result
);
    roc_state_t  state_q;
    logic [15:0] cmd_id_q;
    logic [15:0] count_q;
    logic [31:0] param_q;
    logic [31:0] wb_status_q;
    logic [31:0] next_dflt_q;
    logic [31:0] next_op_q;
    logic [31:0] corr_q;
    logic        rtc_upd_q;
    roc_end_t    end_q;
    roc_end_t    end_d;
    logic [15:0] count_d;
    logic        next_alt_d;
    logic        tick_s1_q;
    logic        tick_s2_q;
    logic        tick_s3_q;
    logic        tick_rise;
    logic        wr_en;
    logic        rd_setup;
    logic        start_wr;
    logic        map_hit;
    logic [31:0] rd_mux;
    logic [7:0]  imm_res;
    logic        done_q;
    logic        ts_q;
    logic        adj_q;
    logic        req_q;
    logic        addr_ok;
    logic        sync_go;

    // apb decode
    // out-of-map writes must not alias onto a register
    assign addr_ok  = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'b00);
    assign wr_en    = psel & penable & pwrite & addr_ok;
    assign rd_setup = psel & ~penable;
    assign start_wr = wr_en & (paddr[7:0] == ROC_A_CTRL) & pwdata[ROC_CTRL_START];
    assign pready   = 1'b1;

    always_comb begin
        map_hit = 1'b1;
        rd_mux  = 32'h0000_0000;
        case (paddr[7:0])
            ROC_A_CTRL:       rd_mux = {30'h0000_0000, rtc_upd_q, 1'b0};
            ROC_A_CMD_ID:     rd_mux = {16'h0000, cmd_id_q};
            ROC_A_COUNT:      rd_mux = {16'h0000, count_q};
            ROC_A_PARAM:      rd_mux = param_q;
            ROC_A_WB_STATUS:  rd_mux = wb_status_q;
            ROC_A_NEXT_DFLT:  rd_mux = next_dflt_q;
            ROC_A_STATUS:     rd_mux = {14'h0000, end_q};
            ROC_A_NEXT_OP:    rd_mux = next_op_q;
            ROC_A_TIMER_CORR: rd_mux = corr_q;
            default:          map_hit = 1'b0;
        endcase
        if (!addr_ok) begin
            map_hit = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~map_hit;
        end
    end

    // software-written structure fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_id_q    <= 16'h0000;
            param_q     <= 32'h0000_0000;
            next_dflt_q <= 32'h0000_0000;
            rtc_upd_q   <= 1'b0;
        end else if (wr_en && state_q == ROC_S_IDLE) begin
            case (paddr[7:0])
                ROC_A_CTRL:      rtc_upd_q   <= pwdata[ROC_CTRL_RTC_UPD];
                ROC_A_CMD_ID:    cmd_id_q    <= pwdata[15:0];
                ROC_A_PARAM:     param_q     <= pwdata;
                ROC_A_NEXT_DFLT: next_dflt_q <= pwdata;
                default: ;
            endcase
        end
    end
    assign rtc_update_enable = rtc_upd_q;

    // rtc tick synchroniser and edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_s1_q <= 1'b0;
            tick_s2_q <= 1'b0;
            tick_s3_q <= 1'b0;
        end else begin
            tick_s1_q <= rtc_tick;
            tick_s2_q <= tick_s1_q;
            tick_s3_q <= tick_s2_q;
        end
    end
    assign tick_rise = tick_s2_q & ~tick_s3_q;

    // embedded command result mapping
    assign imm_res = imm_status_word[7:0];

    // end status computation
    always_comb begin
        end_d.status = ROC_ST_OK;
        end_d.result = ROC_RESULT_TRUE;
        count_d      = count_q;
        next_alt_d   = 1'b0;
        case (state_q)
            ROC_S_DISPATCH: begin
                case (cmd_id_q)
                    ROC_ID_COUNT: begin
                        if (count_q == ROC_CNT_ZERO) begin
                            end_d.status = ROC_ST_PARAM_ERR;
                            end_d.result = ROC_RESULT_ABORT;
                        end else begin
                            count_d = count_q - ROC_CNT_ONE;
                            if (count_d == ROC_CNT_ZERO) begin
                                end_d.status = ROC_ST_COUNTDOWN;
                                end_d.result = ROC_RESULT_FALSE;
                            end
                        end
                    end
                    ROC_ID_CNT_BRANCH: begin
                        if (count_q == ROC_CNT_ZERO) begin
                            next_alt_d = 1'b1;
                        end else begin
                            count_d = count_q - ROC_CNT_ONE;
                            if (count_d == ROC_CNT_ZERO) begin
                                end_d.status = ROC_ST_COUNTDOWN;
                                end_d.result = ROC_RESULT_FALSE;
                            end else begin
                                next_alt_d = 1'b1;
                            end
                        end
                    end
                    default: begin
                        end_d.status = ROC_ST_PARAM_ERR;
                        end_d.result = ROC_RESULT_ABORT;
                    end
                endcase
            end
            ROC_S_SCH_RUN: begin
                case (imm_res)
                    ROC_RES_DONE: begin
                        end_d.status = ROC_ST_OK;
                        end_d.result = ROC_RESULT_TRUE;
                    end
                    ROC_RES_SCHED,
                    ROC_RES_UNK_CMD,
                    ROC_RES_UNK_DIR,
                    ROC_RES_BAD_PTR,
                    ROC_RES_PAR_ERR: begin
                        end_d.status = ROC_ST_PARAM_ERR;
                        end_d.result = ROC_RESULT_ABORT;
                    end
                    default: begin
                        end_d.status = ROC_ST_FAILED;
                        end_d.result = ROC_RESULT_FALSE;
                    end
                endcase
            end
            default: ;
        endcase
    end

    // operation sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ROC_S_IDLE;
        end else begin
            // one operation at a time; starts while busy are dropped
            case (state_q)
                ROC_S_IDLE: begin
                    if (start_wr) begin
                        state_q <= ROC_S_DISPATCH;
                    end
                end
                ROC_S_DISPATCH: begin
                    case (cmd_id_q)
                        ROC_ID_SYNC_START: state_q <= ROC_S_SYNC_WAIT;
                        ROC_ID_SCH_IMM:    state_q <= ROC_S_SCH_HOLD;
                        default:           state_q <= ROC_S_FINISH;
                    endcase
                end
                ROC_S_SYNC_WAIT: begin
                    if (tick_rise) begin
                        state_q <= ROC_S_FINISH;
                    end
                end
                ROC_S_SCH_HOLD: begin
                    if (!command_register_busy) begin
                        state_q <= ROC_S_SCH_RUN;
                    end
                end
                ROC_S_SCH_RUN: begin
                    if (imm_done) begin
                        state_q <= ROC_S_FINISH;
                    end
                end
                ROC_S_FINISH: state_q <= ROC_S_IDLE;
                default:      state_q <= ROC_S_IDLE;
            endcase
        end
    end

    // end status, count write-back and next pointer, all at one edge
    // software never sees a new count with a stale status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            end_q     <= '{status: ROC_ST_IDLE, result: ROC_RESULT_NONE};
            count_q   <= 16'h0000;
            next_op_q <= 32'h0000_0000;
        end else begin
            if (start_wr && state_q == ROC_S_IDLE) begin
                end_q <= '{status: ROC_ST_ACTIVE, result: ROC_RESULT_NONE};
            end else if (state_q == ROC_S_DISPATCH
                         && cmd_id_q != ROC_ID_SYNC_START
                         && cmd_id_q != ROC_ID_SCH_IMM) begin
                end_q     <= end_d;
                count_q   <= count_d;
                next_op_q <= next_alt_d ? param_q : next_dflt_q;
            end else if (state_q == ROC_S_SYNC_WAIT && tick_rise) begin
                end_q     <= '{status: ROC_ST_OK, result: ROC_RESULT_TRUE};
                next_op_q <= next_dflt_q;
            end else if (state_q == ROC_S_SCH_RUN && imm_done) begin
                end_q     <= end_d;
                next_op_q <= next_dflt_q;
            end else if (wr_en && state_q == ROC_S_IDLE
                         && paddr[7:0] == ROC_A_COUNT) begin
                count_q <= pwdata[15:0];
            end
        end
    end

    assign sync_go = state_q == ROC_S_DISPATCH && cmd_id_q == ROC_ID_SYNC_START;

    // sync timer start: start, arm capture, correct on tick
    // correction uses the timer value seen at the synced tick edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ts_q            <= 1'b0;
            rtc_capture_arm <= 1'b0;
            adj_q           <= 1'b0;
            corr_q          <= 32'h0000_0000;
        end else begin
            ts_q  <= sync_go;
            adj_q <= 1'b0;
            if (sync_go) begin
                rtc_capture_arm <= 1'b1;
            end else if (state_q == ROC_S_SYNC_WAIT && tick_rise) begin
                rtc_capture_arm <= 1'b0;
                adj_q           <= 1'b1;
                corr_q          <= param_q - timer_value;
            end
        end
    end
    assign timer_start        = ts_q;
    assign timer_adjust       = adj_q;
    assign timer_adjust_value = corr_q;

    // scheduled immediate command issue and status capture
    // the request waits until the command register path is idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q       <= 1'b0;
            imm_word    <= 32'h0000_0000;
            wb_status_q <= 32'h0000_0000;
        end else begin
            req_q <= 1'b0;
            if (state_q == ROC_S_SCH_HOLD && !command_register_busy) begin
                req_q    <= 1'b1;
                imm_word <= param_q;
            end
            if (state_q == ROC_S_SCH_RUN && imm_done) begin
                wb_status_q <= imm_status_word;
            end
        end
    end
    assign imm_req = req_q;

    // command-done event for every operation, no acknowledge event
    // the pulse follows the edge at which end status settles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
        end else begin
            done_q <= state_q == ROC_S_FINISH;
        end
    end
    assign op_done   = done_q;
    assign op_result = end_q.result;
endmodule // roc_ctrl_cmds
`default_nettype wire

//--- rtl/roc_pkg.sv
// roc_pkg: constants and types for the radio operation control commands
package roc_pkg;
    // command codes
    localparam logic [15:0] ROC_ID_SYNC_START = 16'h080A;
    localparam logic [15:0] ROC_ID_COUNT      = 16'h080B;
    localparam logic [15:0] ROC_ID_SCH_IMM    = 16'h0810;
    localparam logic [15:0] ROC_ID_CNT_BRANCH = 16'h0812;
    // end status codes
    localparam logic [15:0] ROC_ST_IDLE       = 16'h0000;
    localparam logic [15:0] ROC_ST_ACTIVE     = 16'h0001;
    localparam logic [15:0] ROC_ST_OK         = 16'h0010;
    localparam logic [15:0] ROC_ST_COUNTDOWN  = 16'h0011;
    localparam logic [15:0] ROC_ST_FAILED     = 16'h0012;
    localparam logic [15:0] ROC_ST_PARAM_ERR  = 16'h0020;
    // embedded command result bytes
    localparam logic [7:0]  ROC_RES_DONE      = 8'h01;
    localparam logic [7:0]  ROC_RES_SCHED     = 8'h81;
    localparam logic [7:0]  ROC_RES_UNK_CMD   = 8'h82;
    localparam logic [7:0]  ROC_RES_UNK_DIR   = 8'h83;
    localparam logic [7:0]  ROC_RES_BAD_PTR   = 8'h84;
    localparam logic [7:0]  ROC_RES_PAR_ERR   = 8'h85;
    // register byte offsets
    localparam logic [7:0]  ROC_A_CTRL        = 8'h00;
    localparam logic [7:0]  ROC_A_CMD_ID      = 8'h04;
    localparam logic [7:0]  ROC_A_COUNT       = 8'h08;
    localparam logic [7:0]  ROC_A_PARAM       = 8'h0C;
    localparam logic [7:0]  ROC_A_WB_STATUS   = 8'h10;
    localparam logic [7:0]  ROC_A_NEXT_DFLT   = 8'h14;
    localparam logic [7:0]  ROC_A_STATUS      = 8'h18;
    localparam logic [7:0]  ROC_A_NEXT_OP     = 8'h1C;
    localparam logic [7:0]  ROC_A_TIMER_CORR  = 8'h20;
    // ctrl field positions
    localparam int          ROC_CTRL_START    = 0;
    localparam int          ROC_CTRL_RTC_UPD  = 1;
    // small constants
    localparam logic [15:0] ROC_CNT_ONE       = 16'h0001;
    localparam logic [15:0] ROC_CNT_ZERO      = 16'h0000;

    typedef enum logic [1:0] {
        ROC_RESULT_NONE  = 2'b00,
        ROC_RESULT_TRUE  = 2'b01,
        ROC_RESULT_FALSE = 2'b10,
        ROC_RESULT_ABORT = 2'b11
    } roc_result_t;

    typedef struct packed {
        logic [15:0] status;
        roc_result_t result;
    } roc_end_t;

    typedef enum logic [2:0] {
        ROC_S_IDLE      = 3'b000,
        ROC_S_DISPATCH  = 3'b001,
        ROC_S_SYNC_WAIT = 3'b010,
        ROC_S_SCH_HOLD  = 3'b011,
        ROC_S_SCH_RUN   = 3'b100,
        ROC_S_FINISH    = 3'b101
    } roc_state_t;
endpackage

//--- tb/roc_chk_checker.sv
// assertions on the control command block ports
`timescale 1ns/10ps
`default_nettype none
module roc_chk
    import roc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        timer_start,
    input wire logic        rtc_capture_arm,
    input wire logic        command_register_busy,
    input wire logic        imm_req,
    input wire logic        imm_done,
    input wire logic [31:0] imm_status_word,
    input wire logic        op_done,
    input wire logic [1:0]  op_result
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] res;
    assign res = imm_status_word[7:0];
    a_busy_defer: assert property (imm_req |-> $past(!command_register_busy))
        else $error("embedded request while busy");
    a_req_pulse: assert property (imm_req |=> !imm_req)
        else $error("embedded request too long");
    a_start_arm: assert property (timer_start |-> ##[0:1] rtc_capture_arm)
        else $error("capture not armed");
    a_start_pulse: assert property (timer_start |=> !timer_start)
        else $error("timer start too long");
    a_done_pulse: assert property (op_done |=> !op_done)
        else $error("done event too long");
    a_done_result: assert property (op_done |-> op_result != ROC_RESULT_NONE)
        else $error("done without result");
    a_sch_ok: assert property (imm_done && res == ROC_RES_DONE
        |-> ##[1:6] op_done && op_result == ROC_RESULT_TRUE) else $error("ok map");
    a_sch_abort: assert property (imm_done && res inside {[8'h81:8'h85]}
        |-> ##[1:6] op_done && op_result == ROC_RESULT_ABORT) else $error("abort map");
    a_sch_fail: assert property (imm_done && res == 8'h90
        |-> ##[1:6] op_done && op_result == ROC_RESULT_FALSE) else $error("fail map");
    cover property (op_done && op_result == ROC_RESULT_TRUE);
    cover property (op_done && op_result == ROC_RESULT_FALSE);
    cover property (op_done && op_result == ROC_RESULT_ABORT);
endmodule // roc_chk
bind roc_ctrl_cmds roc_chk u_chk (.pclk, .presetn, .timer_start, .rtc_capture_arm,
    .command_register_busy, .imm_req, .imm_done, .imm_status_word, .op_done, .op_result);
`default_nettype wire

//--- tb/roc_radio_model.sv
// model of the radio side: embedded executor, radio timer and rtc tick
`timescale 1ns/10ps
`default_nettype none
module roc_radio_model (
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         slow,
    input wire logic         imm_req,
    input wire logic [31:0]  imm_word,
    input wire logic         timer_start,
    output logic             imm_done,
    output logic [31:0]      imm_status_word,
    output logic             rtc_tick,
    output logic [31:0]      timer_value
);
    logic        pend_q;
    logic [2:0]  wait_q;
    logic [31:0] last_q;
    logic [3:0]  tick_q;
    // executor answers with the word's low byte as result code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q          <= 1'b0;
            wait_q          <= 3'h0;
            imm_done        <= 1'b0;
            imm_status_word <= 32'h0000_0000;
            last_q          <= 32'h0000_0000;
        end else begin
            imm_done        <= 1'b0;
            imm_status_word <= ~last_q;
            if (imm_req) begin
                pend_q <= 1'b1;
                wait_q <= slow ? 3'h6 : 3'h0;
            end else if (pend_q && wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
            end else if (pend_q) begin
                pend_q          <= 1'b0;
                imm_done        <= 1'b1;
                imm_status_word <= imm_word;
                last_q          <= imm_word;
            end
        end
    end
    // timer counts every cycle; one tick lasting 4 cycles follows each start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_value <= 32'h0000_0000;
            tick_q      <= 4'h0;
        end else begin
            timer_value <= timer_value + 32'h0000_0001;
            if (timer_start)
                tick_q <= 4'h1;
            else if (tick_q != 4'h0)
                tick_q <= tick_q + 4'h1;
        end
    end
    assign rtc_tick = tick_q[3] & ~tick_q[2];
endmodule // roc_radio_model
`default_nettype wire

//--- tb/roc_ctrl_cmds_test.sv
// self-checking bench for the control command block
`timescale 1ns/10ps
`default_nettype none
module roc_ctrl_cmds_test
    import roc_pkg::*;
;
    localparam logic [31:0] DFLT = 32'h0000_1000;
    localparam logic [31:0] ALT  = 32'h0000_2000;
    // status word reads back as {status, result}
    localparam logic [17:0] OK_T = {ROC_ST_OK, ROC_RESULT_TRUE};
    localparam logic [17:0] CD_F = {ROC_ST_COUNTDOWN, ROC_RESULT_FALSE};
    localparam logic [17:0] PE_A = {ROC_ST_PARAM_ERR, ROC_RESULT_ABORT};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, command_register_busy;
    logic [31:0] paddr, pwdata, prdata, timer_value, timer_adjust_value, imm_word;
    logic [31:0] imm_status_word;
    logic        rtc_tick, timer_start, rtc_capture_arm, timer_adjust, rtc_update_enable;
    logic        imm_req, imm_done, op_done;
    logic [1:0]  op_result;
    int          err_count, num_checks, cyc, req_cnt;
    roc_ctrl_cmds u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rtc_tick, .timer_value, .timer_start, .rtc_capture_arm,
        .timer_adjust, .timer_adjust_value, .rtc_update_enable, .command_register_busy, .imm_req,
        .imm_word, .imm_done, .imm_status_word, .op_done, .op_result);
    roc_radio_model u_radio (.pclk, .presetn, .slow, .imm_req, .imm_word, .timer_start,
        .imm_done, .imm_status_word, .rtc_tick, .timer_value);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (imm_req)
            req_cnt++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic op(input logic [15:0] id, input logic [15:0] c, input logic [31:0] p,
                      input logic [17:0] es, input logic [15:0] ec, input logic [31:0] en);
        logic [31:0] q;
        xfer(1'b1, ROC_A_CMD_ID, {16'h0, id}, q);
        xfer(1'b1, ROC_A_COUNT, {16'h0, c}, q);
        xfer(1'b1, ROC_A_PARAM, p, q);
        xfer(1'b1, ROC_A_NEXT_DFLT, DFLT, q);
        xfer(1'b1, ROC_A_CTRL, 32'h0000_0003, q);
        do @(negedge pclk); while (op_done !== 1'b1);
        xfer(1'b0, ROC_A_STATUS, 32'h0, q);
        chk("status", {14'h0, q[17:0]}, {14'h0, es});
        xfer(1'b0, ROC_A_COUNT, 32'h0, q);
        chk("count", q, {16'h0, ec});
        xfer(1'b0, ROC_A_NEXT_OP, 32'h0, q);
        if (id != ROC_ID_COUNT)
            chk("next", q, en);
        $display("test %h ended", id);
    endtask
    initial begin
        logic [31:0] q, w, off;
        int          n;
        {presetn, psel, penable, pwrite, slow, command_register_busy} = 6'h0;
        {paddr, pwdata} = 64'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, ROC_A_STATUS, 32'h0, q);
        chk("idle", q, 32'h0);
        xfer(1'b0, 8'h40, 32'h0, q);
        chk("unmapped", q, 32'h0);
        chk("unmapped_err", {31'h0, pslverr}, 32'h1);
        op(ROC_ID_COUNT, 16'h0002, 32'h0, OK_T, 16'h0001, 32'h0);
        op(ROC_ID_COUNT, 16'h0001, 32'h0, CD_F, 16'h0000, 32'h0);
        op(ROC_ID_COUNT, 16'h0000, 32'h0, PE_A, 16'h0000, 32'h0);
        op(ROC_ID_CNT_BRANCH, 16'h0005, ALT, OK_T, 16'h0004, ALT);
        op(ROC_ID_CNT_BRANCH, 16'h0001, ALT, CD_F, 16'h0000, DFLT);
        op(ROC_ID_CNT_BRANCH, 16'h0000, ALT, OK_T, 16'h0000, ALT);
        op(ROC_ID_CNT_BRANCH, 16'hFFFF, ALT, OK_T, 16'hFFFE, ALT);
        op(16'h0FFF, 16'h0009, ALT, PE_A, 16'h0009, DFLT);
        for (int i = 0; i < 7; i++) begin
            w = {24'h00_0C5A, (i == 0) ? ROC_RES_DONE : (i == 6) ? 8'h90 : 8'(8'h80 + i)};
            slow      <= i[0];
            command_register_busy <= 1'b1;
            n = req_cnt;
            fork
                op(ROC_ID_SCH_IMM, 16'h0003, w, (i == 0) ? OK_T : (i == 6) ?
                   {ROC_ST_FAILED, ROC_RESULT_FALSE} : PE_A, 16'h0003, DFLT);
                begin
                    repeat (25) @(posedge pclk);
                    chk("deferred", req_cnt, n);
                    command_register_busy <= 1'b0;
                end
            join
            xfer(1'b0, ROC_A_WB_STATUS, 32'h0, q);
            chk("would_be_status", q, w);
        end
        for (int k = 0; k < 2; k++) begin
            off = k ? 32'h1234_5678 : 32'h0000_0000;
            fork
                op(ROC_ID_SYNC_START, 16'h0007, off, OK_T, 16'h0007, DFLT);
                begin
                    do @(negedge pclk); while (timer_adjust !== 1'b1);
                    chk("correction", {31'h0, timer_value - (off - timer_adjust_value) < 6},
                        32'h1);
                    chk("arm_cleared", {31'h0, rtc_capture_arm}, 32'h0);
                end
            join
        end
        chk("rtc_enable", {31'h0, rtc_update_enable}, 32'h1);
        final_report();
    end
endmodule // roc_ctrl_cmds_test
`default_nettype wire
